// ===== logic/bae_exec.sv
// execution datapath: rotates, subtract, nibble swap, xor, direction load, sleep
// assumes the decoder presents one op at a time and waits for o_ready
`timescale 1ns/10ps
module bae_exec
#(
  parameter bit DIR_B_PRESENT = 1'b1
)
(
  input wire logic i_ref_clk, // core clock, 10 MHz
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_op_valid, // decoder offers an op
  input wire bae_pkg::bae_op_type i_op, // op, operand and literal
  input wire logic i_fwr_valid, // external file write, taken when idle
  input wire logic [4:0] i_fwr_addr, // external write address
  input wire logic [7:0] i_fwr_data, // external write data
  input wire logic i_wdt_tick, // prescaler count enable pulse
  input wire logic i_wake_pin, // asynchronous wake request
  input wire logic i_pin_change, // asynchronous pin-change event
  input wire logic i_pin_change_clr, // clear of the pin-change wake flag
  output logic o_ready, // op may be offered
  output logic o_done, // op finished, one cycle
  output logic [7:0] o_w, // working accumulator
  output bae_pkg::bae_flags_type o_flags, // carry, digit carry, zero
  output bae_pkg::bae_power_type o_power, // power status flags
  output logic [7:0] o_dir_a, // direction register six
  output logic [7:0] o_dir_b, // direction register seven
  output logic o_sleep, // core asleep
  output logic o_osc_en, // oscillator running
  output logic [7:0] o_wdt_count // watchdog counter
);
  import bae_pkg::*;

  typedef enum {BAE_IDLE, BAE_EXEC, BAE_SLEEP} bae_state_type;

  bae_state_type state_reg, state_next;
  bae_op_type op_reg, op_next;
  logic [7:0] w_reg, w_next;
  bae_flags_type flags_reg, flags_next;
  bae_power_type power_reg, power_next;
  logic [7:0] dir_a_reg, dir_a_next, dir_b_reg, dir_b_next;
  logic done_reg, done_next, ready_reg, osc_reg, sleep_reg;
  logic [BAE_PRESC_W-1:0] presc_reg, presc_next;
  logic [BAE_WDT_W-1:0] wdt_reg, wdt_next;
  logic sleep_start;
  logic wake_meta_reg, wake_sync_reg, chg_meta_reg, chg_sync_reg;
  logic mem_we;
  logic [4:0] mem_waddr;
  logic [7:0] mem_wdata, rd_data;
  logic [8:0] sub_full;
  logic [4:0] sub_nib;

  bae_file_mem #(
    .ADDR_W(BAE_ADDR_W),
    .DATA_W(BAE_DATA_W),
    .DEPTH(BAE_FILE_DEPTH)
  ) u_file (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(i_op.faddr),
    .o_rdata(rd_data)
  );

  // pins pass two flops before anything looks at them
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
      chg_meta_reg <= 1'b0;
      chg_sync_reg <= 1'b0;
    end
    else
    begin
      wake_meta_reg <= i_wake_pin;
      wake_sync_reg <= wake_meta_reg;
      chg_meta_reg <= i_pin_change;
      chg_sync_reg <= chg_meta_reg;
    end
  end

  // subtract as f + ~w + 1: carry out means no borrow
  assign sub_full = {1'b0, rd_data} + {1'b0, ~w_reg} + 9'h001;
  assign sub_nib = {1'b0, rd_data[3:0]} + {1'b0, ~w_reg[3:0]} + 5'h01;

  always_comb
  begin
    logic [7:0] res;
    res = rd_data;
    state_next = state_reg;
    op_next = op_reg;
    w_next = w_reg;
    flags_next = flags_reg;
    power_next = power_reg;
    dir_a_next = dir_a_reg;
    dir_b_next = dir_b_reg;
    done_next = 1'b0;
    sleep_start = 1'b0;
    mem_we = 1'b0;
    mem_waddr = i_fwr_addr;
    mem_wdata = i_fwr_data;
    case (state_reg)
      BAE_IDLE:
      begin
        mem_we = i_fwr_valid;
        if (i_op_valid)
        begin
          op_next = i_op;
          case (i_op.code)
            BAE_LITERAL_XOR_OP:
            begin
              w_next = w_reg ^ i_op.literal;
              flags_next.zero = ((w_reg ^ i_op.literal) == 8'h00);
              done_next = 1'b1;
            end
            BAE_DIR_LOAD_OP:
            begin
              if (i_op.faddr == BAE_DIR_A_SEL)
              begin
                dir_a_next = w_reg;
              end
              else if (i_op.faddr == BAE_DIR_B_SEL && DIR_B_PRESENT)
              begin
                dir_b_next = w_reg;
              end
              done_next = 1'b1;
            end
            BAE_SLEEP_OP:
            begin
              sleep_start = 1'b1;
              power_next.timeout_flag = 1'b1;
              power_next.powerdown_flag = 1'b0;
              state_next = BAE_SLEEP;
              done_next = 1'b1;
            end
            default:
            begin
              // file operand is being read this cycle; finish next cycle
              state_next = BAE_EXEC;
            end
          endcase
        end
      end
      BAE_EXEC:
      begin
        case (op_reg.code)
          BAE_ROTATE_LEFT_OP:
          begin
            res = {rd_data[BAE_MSB-1:0], flags_reg.carry};
            flags_next.carry = rd_data[BAE_MSB];
          end
          BAE_ROTATE_RIGHT_OP:
          begin
            res = {flags_reg.carry, rd_data[BAE_MSB:1]};
            flags_next.carry = rd_data[0];
          end
          BAE_SUBTRACT_OP:
          begin
            res = sub_full[7:0];
            flags_next.carry = sub_full[8];
            flags_next.digit_carry_flag = sub_nib[4];
            flags_next.zero = (sub_full[7:0] == 8'h00);
          end
          BAE_NIBBLE_SWAP_OP:
          begin
            res = {rd_data[3:0], rd_data[7:4]};
          end
          default:
          begin
            res = rd_data ^ w_reg;
            flags_next.zero = ((rd_data ^ w_reg) == 8'h00);
          end
        endcase
        if (op_reg.dest == BAE_DEST_FILE)
        begin
          mem_we = 1'b1;
          mem_waddr = op_reg.faddr;
          mem_wdata = res;
        end
        else
        begin
          w_next = res;
        end
        state_next = BAE_IDLE;
        done_next = 1'b1;
      end
      default:
      begin
        // asleep: oscillator is stopped until the synchronised wake pin is seen high
        if (wake_sync_reg)
        begin
          state_next = BAE_IDLE;
        end
      end
    endcase
    // a pin-change event wins over a clear in the same cycle
    if (i_pin_change_clr)
    begin
      power_next.pin_change_wake_flag = 1'b0;
    end
    if (chg_sync_reg)
    begin
      power_next.pin_change_wake_flag = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state_reg <= BAE_IDLE;
      op_reg <= '0;
      w_reg <= BAE_W_RESET;
      flags_reg <= '0;
      power_reg <= {BAE_TIMEOUT_RESET, BAE_POWERDOWN_RESET, 1'b0};
      dir_a_reg <= BAE_DIR_RESET;
      dir_b_reg <= BAE_DIR_RESET;
      done_reg <= 1'b0;
      ready_reg <= 1'b0;
      osc_reg <= 1'b1;
      sleep_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      w_reg <= w_next;
      flags_reg <= flags_next;
      power_reg <= power_next;
      dir_a_reg <= dir_a_next;
      dir_b_reg <= dir_b_next;
      done_reg <= done_next;
      ready_reg <= (state_next == BAE_IDLE);
      osc_reg <= (state_next != BAE_SLEEP);
      sleep_reg <= (state_next == BAE_SLEEP);
    end
  end

  // watchdog: a sleep clear beats a tick in the same cycle
  always_comb
  begin
    presc_next = presc_reg;
    wdt_next = wdt_reg;
    if (sleep_start)
    begin
      presc_next = BAE_PRESC_CLEAR;
      wdt_next = BAE_WDT_CLEAR;
    end
    else if (i_wdt_tick)
    begin
      presc_next = presc_reg + 8'h01;
      if (presc_reg == 8'hff)
      begin
        wdt_next = wdt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      presc_reg <= BAE_PRESC_CLEAR;
      wdt_reg <= BAE_WDT_CLEAR;
    end
    else
    begin
      presc_reg <= presc_next;
      wdt_reg <= wdt_next;
    end
  end

  assign o_ready = ready_reg;
  assign o_done = done_reg;
  assign o_w = w_reg;
  assign o_flags = flags_reg;
  assign o_power = power_reg;
  assign o_dir_a = dir_a_reg;
  assign o_dir_b = dir_b_reg;
  assign o_sleep = sleep_reg;
  assign o_osc_en = osc_reg;
  assign o_wdt_count = wdt_reg;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence take_op(bae_opcode_type c);
    state_reg == BAE_IDLE && i_op_valid && i_op.code == c;
  endsequence

  sequence exec_op(bae_opcode_type c);
    state_reg == BAE_EXEC && op_reg.code == c;
  endsequence

  sleep_wdt_clear_a: assert property (take_op(BAE_SLEEP_OP) |=>
    wdt_reg == BAE_WDT_CLEAR && presc_reg == BAE_PRESC_CLEAR)
    else $error("watchdog not cleared by sleep");
  sleep_power_flags_a: assert property (take_op(BAE_SLEEP_OP) ##0 (!chg_sync_reg
    && !i_pin_change_clr) |=> o_power.timeout_flag && !o_power.powerdown_flag
    && o_power.pin_change_wake_flag == $past(power_reg.pin_change_wake_flag))
    else $error("sleep power flags wrong");
  sleep_osc_stop_a: assert property (take_op(BAE_SLEEP_OP) ##1 !wake_sync_reg
    |=> !o_osc_en && o_sleep && !o_ready)
    else $error("oscillator still running in sleep");
  dest_route_a: assert property (state_reg == BAE_EXEC |->
    mem_we == op_reg.dest
    && (!op_reg.dest || (mem_waddr == op_reg.faddr && w_next == w_reg)))
    else $error("result routed to wrong destination");
  rotate_left_a: assert property (exec_op(BAE_ROTATE_LEFT_OP) |=>
    o_flags.carry == $past(rd_data[7]) && o_flags.zero == $past(flags_reg.zero)
    && o_flags.digit_carry_flag == $past(flags_reg.digit_carry_flag))
    else $error("rotate left flags wrong");
  rotate_right_a: assert property (exec_op(BAE_ROTATE_RIGHT_OP) ##0 !op_reg.dest |=>
    o_w == {$past(flags_reg.carry), $past(rd_data[7:1])} && o_flags.carry == $past(rd_data[0]))
    else $error("rotate right result wrong");
  subtract_a: assert property (exec_op(BAE_SUBTRACT_OP) ##0 !op_reg.dest |=>
    o_w == $past(rd_data) - $past(w_reg) && o_flags.carry == ($past(rd_data) >= $past(w_reg)))
    else $error("subtract result or carry wrong");
  swap_flags_a: assert property (exec_op(BAE_NIBBLE_SWAP_OP) |=> $stable(o_flags))
    else $error("swap touched flags");
  dir_load_a: assert property (take_op(BAE_DIR_LOAD_OP) ##0 i_op.faddr == BAE_DIR_A_SEL
    |=> o_dir_a == $past(w_reg) && $stable(o_flags) ##1 o_ready)
    else $error("direction load wrong");
  reg_xor_a: assert property (exec_op(BAE_REGISTER_XOR_OP) |=>
    o_flags.zero == ($past(rd_data) == $past(w_reg)) && o_flags.carry == $past(flags_reg.carry))
    else $error("register xor zero flag wrong");
  lit_xor_a: assert property (take_op(BAE_LITERAL_XOR_OP) |=>
    o_w == ($past(w_reg) ^ $past(i_op.literal)) && o_done)
    else $error("literal xor result wrong");
endmodule

// ===== logic/bae_pkg.sv
// shared constants and carrier types for the byte alu / sleep execution block
// assumes a single 10 MHz core clock and a synchronous active-high reset
package bae_pkg;
  localparam int BAE_ADDR_W = 5;
  localparam int BAE_DATA_W = 8;
  localparam int BAE_FILE_DEPTH = 32;
  localparam int BAE_PRESC_W = 8;
  localparam int BAE_WDT_W = 8;
  localparam int BAE_MSB = 7;
  localparam logic [7:0] BAE_W_RESET = 8'h00;
  localparam logic [7:0] BAE_DIR_RESET = 8'hff;
  localparam logic [4:0] BAE_DIR_A_SEL = 5'h06;
  localparam logic [4:0] BAE_DIR_B_SEL = 5'h07;
  localparam logic [7:0] BAE_WDT_CLEAR = 8'h00;
  localparam logic [7:0] BAE_PRESC_CLEAR = 8'h00;
  localparam logic BAE_TIMEOUT_RESET = 1'b1;
  localparam logic BAE_POWERDOWN_RESET = 1'b1;
  localparam logic BAE_DEST_W = 1'b0;
  localparam logic BAE_DEST_FILE = 1'b1;

  typedef enum logic [2:0] {
    BAE_ROTATE_LEFT_OP,
    BAE_ROTATE_RIGHT_OP,
    BAE_SUBTRACT_OP,
    BAE_NIBBLE_SWAP_OP,
    BAE_REGISTER_XOR_OP,
    BAE_LITERAL_XOR_OP,
    BAE_DIR_LOAD_OP,
    BAE_SLEEP_OP
  } bae_opcode_type;

  typedef struct packed {
    bae_opcode_type code;
    logic [4:0] faddr;
    logic dest;
    logic [7:0] literal;
  } bae_op_type;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } bae_flags_type;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic pin_change_wake_flag;
  } bae_power_type;
endpackage

// ===== logic/bae_file_mem.sv
// 32-entry data file register array with a registered read port
// assumes one writer per cycle; a read of the written address returns the old value
`timescale 1ns/10ps
module bae_file_mem
#(
  parameter int ADDR_W = 5,
  parameter int DATA_W = 8,
  parameter int DEPTH = 32
)
(
  input wire logic i_ref_clk, // core clock
  input wire logic i_rst, // synchronous reset
  input wire logic i_we, // write strobe
  input wire logic [ADDR_W-1:0] i_waddr, // write address
  input wire logic [DATA_W-1:0] i_wdata, // write data
  input wire logic [ADDR_W-1:0] i_raddr, // read address
  output logic [DATA_W-1:0] o_rdata // read data, one cycle later
);
  logic [DATA_W-1:0] mem_reg [DEPTH];
  logic [DATA_W-1:0] rdata_reg;

  // the array itself carries no reset; only the read register does
  always_ff @(posedge i_ref_clk)
  begin
    if (i_we)
    begin
      mem_reg[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      rdata_reg <= '0;
    end
    else
    begin
      rdata_reg <= mem_reg[i_raddr];
    end
  end

  assign o_rdata = rdata_reg;
endmodule

// ===== verification/bae_dec_model.sv
// decoder and file loader model that offers ops and external file writes
// assumes inputs are settled at the falling edge, where all its outputs change
`timescale 1ns/10ps
module bae_dec_model
  import bae_pkg::*;
(
  input wire logic i_ref_clk, // core clock
  input wire logic i_ready, // block idle
  input wire logic i_done, // op finished pulse
  output bae_pkg::bae_op_type o_op, // op fields
  output logic o_op_valid, // op offered
  output logic o_fwr_valid, // file write strobe
  output logic [4:0] o_fwr_addr, // file write address
  output logic [7:0] o_fwr_data // file write data
);
  initial
  begin
    o_op = '0;
    o_op_valid = 1'b0;
    o_fwr_valid = 1'b0;
    o_fwr_addr = 5'h00;
    o_fwr_data = 8'h00;
  end

  // released fields are inverted so stale values never look valid
  task automatic fwrite(input logic [4:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_fwr_valid = 1'b1;
    o_fwr_addr = a;
    o_fwr_data = d;
    @(negedge i_ref_clk);
    o_fwr_valid = 1'b0;
    o_fwr_addr = ~a;
    o_fwr_data = ~d;
  endtask

  // n counts falling edges from the offer until done, capped at 40
  task automatic issue(input bae_opcode_type c, input logic [4:0] fa, input logic d,
                       input logic [7:0] k, output int n);
    // one idle edge first, so valid never drops and rises in one time step
    n = 0;
    @(negedge i_ref_clk);
    while (i_ready !== 1'b1 && n < 40)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n < 40)
    begin
      o_op_valid = 1'b1;
      o_op = '{c, fa, d, k};
      @(negedge i_ref_clk);
      o_op_valid = 1'b0;
      o_op = bae_op_type'(~o_op);
      n = 1;
      while (i_done !== 1'b1 && n < 40)
      begin
        @(negedge i_ref_clk);
        n++;
      end
    end
  endtask
endmodule

// ===== verification/bae_exec_tb_top.sv
// self-checking bench for the execution datapath, ops offered by the decoder model
// assumes the design's default with direction register seven present
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module bae_exec_tb_top;
  import bae_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wdt_tick = 1'b0;
  logic i_wake_pin = 1'b0;
  logic i_pin_change = 1'b0;
  logic i_pin_change_clr = 1'b0;
  logic op_valid, fwr_valid, o_ready, o_done, o_sleep, o_osc_en;
  bae_op_type op;
  logic [4:0] fwr_addr;
  logic [7:0] fwr_data, o_w, o_dir_a, o_dir_b, o_wdt_count;
  bae_flags_type o_flags;
  bae_power_type o_power;
  int errors = 0;
  int check_count = 0;
  int n;

  always #50 i_ref_clk = ~i_ref_clk;

  bae_exec u_bae_exec (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_op_valid(op_valid),
    .i_op(op), .i_fwr_valid(fwr_valid), .i_fwr_addr(fwr_addr), .i_fwr_data(fwr_data),
    .i_wdt_tick(i_wdt_tick), .i_wake_pin(i_wake_pin), .i_pin_change(i_pin_change),
    .i_pin_change_clr(i_pin_change_clr), .o_ready(o_ready), .o_done(o_done), .o_w(o_w),
    .o_flags(o_flags), .o_power(o_power), .o_dir_a(o_dir_a), .o_dir_b(o_dir_b),
    .o_sleep(o_sleep), .o_osc_en(o_osc_en), .o_wdt_count(o_wdt_count));

  bae_dec_model u_bae_dec_model (.i_ref_clk(i_ref_clk), .i_ready(o_ready), .i_done(o_done),
    .o_op(op), .o_op_valid(op_valid), .o_fwr_valid(fwr_valid), .o_fwr_addr(fwr_addr),
    .o_fwr_data(fwr_data));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one op, then its latency, accumulator and {carry, digit carry, zero}
  task automatic run(input bae_opcode_type c, input logic [4:0] fa, input logic d,
                     input logic [7:0] k, input int lat, input logic [7:0] ew,
                     input logic [2:0] ef);
    u_bae_dec_model.issue(c, fa, d, k, n);
    if (n >= 40)
    begin
      errors++;
      give_verdict();
    end
    `CHK("latency", lat, n)
    `CHK("accumulator", ew, o_w)
    `CHK("flags", ef, o_flags)
  endtask

  // ticks spaced a cycle apart so each is a clean pulse
  task automatic ticks(input int c);
    repeat (c)
    begin
      @(negedge i_ref_clk);
      i_wdt_tick = 1'b1;
      @(negedge i_ref_clk);
      i_wdt_tick = 1'b0;
    end
  endtask

  initial
  begin
    repeat (6) @(negedge i_ref_clk);
    i_rst = 1'b0;
    @(negedge i_ref_clk);
    @(negedge i_ref_clk);
    `CHK("reset accumulator", 8'h00, o_w)
    `CHK("reset power", 3'b110, o_power)
    `CHK("reset dir", 16'hffff, {o_dir_a, o_dir_b})
    $display("test reset done");
    u_bae_dec_model.fwrite(5'h03, 8'h96);
    u_bae_dec_model.fwrite(5'h1f, 8'h81);
    run(BAE_LITERAL_XOR_OP, 5'h00, 1'b0, 8'h5a, 1, 8'h5a, 3'b000);
    run(BAE_LITERAL_XOR_OP, 5'h00, 1'b0, 8'h5a, 1, 8'h00, 3'b001);
    $display("test literal xor done");
    run(BAE_ROTATE_LEFT_OP, 5'h03, 1'b0, 8'h00, 2, 8'h2c, 3'b101);
    run(BAE_ROTATE_LEFT_OP, 5'h03, 1'b1, 8'h00, 2, 8'h2c, 3'b101);
    run(BAE_ROTATE_RIGHT_OP, 5'h03, 1'b0, 8'h00, 2, 8'h96, 3'b101);
    run(BAE_ROTATE_RIGHT_OP, 5'h1f, 1'b0, 8'h00, 2, 8'hc0, 3'b101);
    run(BAE_NIBBLE_SWAP_OP, 5'h1f, 1'b0, 8'h00, 2, 8'h18, 3'b101);
    $display("test rotate and swap done");
    run(BAE_SUBTRACT_OP, 5'h03, 1'b0, 8'h00, 2, 8'h15, 3'b110);
    run(BAE_SUBTRACT_OP, 5'h1f, 1'b1, 8'h00, 2, 8'h15, 3'b100);
    run(BAE_REGISTER_XOR_OP, 5'h1f, 1'b0, 8'h00, 2, 8'h79, 3'b100);
    run(BAE_SUBTRACT_OP, 5'h03, 1'b1, 8'h00, 2, 8'h79, 3'b010);
    run(BAE_REGISTER_XOR_OP, 5'h03, 1'b1, 8'h00, 2, 8'h79, 3'b010);
    run(BAE_LITERAL_XOR_OP, 5'h00, 1'b0, 8'hb4, 1, 8'hcd, 3'b010);
    run(BAE_REGISTER_XOR_OP, 5'h03, 1'b0, 8'h00, 2, 8'h00, 3'b011);
    $display("test subtract and xor done");
    run(BAE_LITERAL_XOR_OP, 5'h00, 1'b0, 8'h68, 1, 8'h68, 3'b010);
    run(BAE_DIR_LOAD_OP, 5'h06, 1'b0, 8'h00, 1, 8'h68, 3'b010);
    run(BAE_LITERAL_XOR_OP, 5'h00, 1'b0, 8'hff, 1, 8'h97, 3'b010);
    run(BAE_DIR_LOAD_OP, 5'h07, 1'b0, 8'h00, 1, 8'h97, 3'b010);
    run(BAE_DIR_LOAD_OP, 5'h05, 1'b0, 8'h00, 1, 8'h97, 3'b010);
    `CHK("direction pair", 16'h6897, {o_dir_a, o_dir_b})
    $display("test direction load done");
    ticks(300);
    @(negedge i_ref_clk);
    i_pin_change = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    i_pin_change = 1'b0;
    `CHK("watchdog before sleep", 8'h01, o_wdt_count)
    `CHK("power before sleep", 3'b111, o_power)
    run(BAE_SLEEP_OP, 5'h00, 1'b0, 8'h00, 1, 8'h97, 3'b010);
    `CHK("watchdog cleared", 8'h00, o_wdt_count)
    `CHK("power in sleep", 3'b101, o_power)
    `CHK("asleep, clock stopped", 3'b100, {o_sleep, o_osc_en, o_ready})
    repeat (5) @(negedge i_ref_clk);
    `CHK("still asleep", 3'b100, {o_sleep, o_osc_en, o_ready})
    i_wake_pin = 1'b1;
    n = 0;
    while (o_ready !== 1'b1 && n < 20)
    begin
      @(negedge i_ref_clk);
      n++;
    end
    i_wake_pin = 1'b0;
    if (n >= 20)
    begin
      errors++;
      give_verdict();
    end
    `CHK("wake delay", 3, n)
    `CHK("awake", 2'b01, {o_sleep, o_osc_en})
    ticks(255);
    `CHK("prescaler cleared", 8'h00, o_wdt_count)
    @(negedge i_ref_clk);
    i_pin_change_clr = 1'b1;
    @(negedge i_ref_clk);
    i_pin_change_clr = 1'b0;
    `CHK("power after clear", 3'b100, o_power)
    $display("test sleep done");
    give_verdict();
  end
endmodule
